// ### logic/cfs_cfg.svh
`ifndef CFS_CFG_SVH
`define CFS_CFG_SVH
`define CFS_CLK_HZ 50000000
`define CFS_SHORT_OFF_US 1000
`define CFS_SHORT_OFF_CYC ((`CFS_SHORT_OFF_US * (`CFS_CLK_HZ / 1000000)) / 1)
`define CFS_STEP_US 1600
`define CFS_STEP_CYC (`CFS_STEP_US * (`CFS_CLK_HZ / 1000000))
`define CFS_OV_US 30000
`define CFS_OV_CYC (`CFS_OV_US * (`CFS_CLK_HZ / 1000000))
`define CFS_BLINK_CYC 25000000
`define CFS_SS_STEPS 8
`define CFS_FB_NORMAL 2'h0
`define CFS_FB_COLD 2'h1
`define CFS_FB_WARM 2'h2
`endif

// ### logic/cfs_pkg.sv
`default_nettype none
package cfs_pkg;
  typedef enum logic [3:0] {
    CFS_IDLE = 4'h1,
    CFS_RUN = 4'h2,
    CFS_SHORT = 4'h4,
    CFS_LATCH = 4'h8
  } cfs_state_type;
endpackage
`default_nettype wire

// ### logic/cfs_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfs_cfg.svh"
// How it works
// R1 - Battery node below short threshold while charging counts as a battery short.
// R2 - On short, converter stops one millisecond, then soft-starts at precharge current.
// R3 - Every soft-start climbs to target current in eight equal 1.6 ms steps.
// R4 - While short persists, low-side switch stays undriven (non-synchronous).
// R5 - High-side turn-on blocked while battery is at or above 102 percent.
// R6 - Discharge sink enabled during battery over-voltage.
// R7 - Over-voltage lasting over thirty milliseconds disables charging.
// R8 - Charge cycle starts only inside the thermistor window; otherwise waits.
// R9 - Leaving the window suspends charging with both switches off; resume inside.
// R10 - Cold zone uses 2.1 V target and half current.
// R11 - Cool zone restores the 2.05 V target.
// R12 - Normal upper zone uses 2.05 V and full current.
// R13 - Warm zone lowers the target to 2.025 V.
// R14 - Switch short latches charger off; adapter path switch stays on.
// R15 - Short latch clears only on adapter removal and reconnection.
// R16 - Short latch makes status output blink.
// R17 - Junction regulation indication reduces charge current.
// R18 - Junction overheat turns converter off until below release point.
// R19 - Timer fault above recharge threshold clears when battery falls below, then detects.
// R20 - Timer fault below threshold applies fault current until battery rises above.
// R21 - Power-on reset or current program disable also clears timer fault.
// R22 - Status transistor on while charging, recharge included.
// R23 - Status off when complete, sleeping or disabled.
// R24 - Status blinks on suspend, input or battery over-voltage, timer fault, absence.
// R25 - Blink toggles at a fixed parameterised rate with equal on and off.
module cfs_supervisor
  import cfs_pkg::*;
#(
  parameter int SHORT_OFF_CYC = `CFS_SHORT_OFF_CYC,
  parameter int STEP_CYC = `CFS_STEP_CYC,
  parameter int OV_CYC = `CFS_OV_CYC,
  parameter int BLINK_CYC = `CFS_BLINK_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic charge_request,
  input wire logic adapter_present,
  input wire logic current_program_disable,
  input wire logic battery_short_cmp,
  input wire logic battery_ov_cmp,
  input wire logic above_cold_window_limit,
  input wire logic above_cool_zone_limit,
  input wire logic above_normal_zone_upper_limit,
  input wire logic above_warm_zone_limit,
  input wire logic above_hot_window_limit,
  input wire logic junction_regulation_hit,
  input wire logic junction_overheat_limit,
  input wire logic junction_release_below,
  input wire logic switch_short_cmp,
  input wire logic timer_expired,
  input wire logic battery_above_recharge,
  input wire logic charge_complete,
  input wire logic input_ov,
  input wire logic battery_absent,
  output logic converter_enable,
  output logic high_side_allow,
  output logic low_side_allow,
  output logic discharge_sink_on,
  output logic precharge_select,
  output logic half_current,
  output logic current_reduce,
  output logic [3:0] soft_start_step,
  output logic [1:0] fb_target_sel,
  output logic adapter_path_switch,
  output logic fault_current_on,
  output logic detect_start,
  output logic status_drive_en,
  output logic status_out
);

  // ****************************************
  // Counters and state
  // ****************************************
  cfs_state_type state_reg, state_next;
  logic [31:0] off_cnt_reg;
  logic [31:0] step_cnt_reg;
  logic [3:0] step_reg;
  logic [31:0] ov_cnt_reg;
  logic ov_disable_reg;
  logic latch_reg;
  logic adapter_d_reg;
  logic overheat_reg;
  logic timer_fault_reg;
  logic detect_reg;
  logic [31:0] blink_cnt_reg;
  logic blink_reg;
  logic short_seen_reg;

  function automatic logic cnt_done(input logic [31:0] c, input int lim);
    cnt_done = (c >= 32'(lim - 1));
  endfunction

  // ****************************************
  // Decoding
  // ****************************************
  wire in_window = above_cold_window_limit && !above_hot_window_limit;
  wire cold_zone = in_window && !above_cool_zone_limit;
  wire warm_zone = in_window && above_warm_zone_limit;
  wire adapter_rise = adapter_present && !adapter_d_reg;
  wire timer_clear = current_program_disable;
  wire ok_to_run = charge_request && adapter_present && !current_program_disable &&
                   in_window && !overheat_reg && !ov_disable_reg && !timer_fault_reg &&
                   !latch_reg && !charge_complete; // R8 R9
  wire charging = (state_reg == CFS_RUN) || (state_reg == CFS_SHORT);
  wire short_now = charging && battery_short_cmp; // R1
  wire off_done = cnt_done(off_cnt_reg, SHORT_OFF_CYC);
  wire step_done = cnt_done(step_cnt_reg, STEP_CYC);
  wire ss_full = (step_reg == 4'(`CFS_SS_STEPS));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CFS_IDLE: begin
        if (ok_to_run) begin
          state_next = CFS_RUN; // R8
        end
      end
      CFS_RUN: begin
        if (!ok_to_run) begin
          state_next = CFS_IDLE; // R9
        end else if (short_now) begin
          state_next = CFS_SHORT; // R2
        end
      end
      CFS_SHORT: begin
        if (!ok_to_run) begin
          state_next = CFS_IDLE;
        end else if (off_done) begin
          state_next = CFS_RUN; // R2
        end
      end
      CFS_LATCH: begin
        state_next = CFS_LATCH;
      end
      default: begin
        state_next = CFS_IDLE;
      end
    endcase
    if (switch_short_cmp && adapter_present) begin
      state_next = CFS_LATCH; // R14
    end else if (state_reg == CFS_LATCH && !latch_reg) begin
      state_next = CFS_IDLE; // R15
    end
  end

  // ****************************************
  // Sequencing
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= CFS_IDLE;
      adapter_d_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      adapter_d_reg <= adapter_present;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      off_cnt_reg <= 32'h0;
    end else if (state_reg == CFS_SHORT) begin
      off_cnt_reg <= off_cnt_reg + 32'h1;
    end else begin
      off_cnt_reg <= 32'h0;
    end
  end

  // Soft-start restarts whenever the converter is not running
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      step_reg <= 4'h0;
      step_cnt_reg <= 32'h0;
    end else if (state_reg != CFS_RUN) begin
      step_reg <= 4'h0;
      step_cnt_reg <= 32'h0;
    end else if (!ss_full) begin
      step_cnt_reg <= step_done ? 32'h0 : step_cnt_reg + 32'h1;
      step_reg <= step_done ? step_reg + 4'h1 : step_reg; // R3
    end
  end

  // Short memory selects precharge level after recovery
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      short_seen_reg <= 1'b0;
    end else if (state_reg == CFS_SHORT) begin
      short_seen_reg <= 1'b1; // R2
    end else if (state_reg == CFS_IDLE) begin
      short_seen_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ov_cnt_reg <= 32'h0;
      ov_disable_reg <= 1'b0;
    end else begin
      ov_cnt_reg <= battery_ov_cmp ? (cnt_done(ov_cnt_reg, OV_CYC) ? ov_cnt_reg :
                    ov_cnt_reg + 32'h1) : 32'h0;
      if (battery_ov_cmp && cnt_done(ov_cnt_reg, OV_CYC)) begin
        ov_disable_reg <= 1'b1; // R7
      end else if (!adapter_present || current_program_disable) begin
        ov_disable_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latch_reg <= 1'b0;
    end else if (switch_short_cmp && adapter_present) begin
      latch_reg <= 1'b1; // R14
    end else if (adapter_rise) begin
      latch_reg <= 1'b0; // R15
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      overheat_reg <= 1'b0;
    end else if (junction_overheat_limit) begin
      overheat_reg <= 1'b1; // R18
    end else if (junction_release_below) begin
      overheat_reg <= 1'b0; // R18
    end
  end

  // Timer fault: set wins over clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_fault_reg <= 1'b0; // R21
      detect_reg <= 1'b0;
    end else begin
      detect_reg <= 1'b0;
      if (timer_expired && charging) begin
        timer_fault_reg <= 1'b1;
      end else if (timer_clear) begin
        timer_fault_reg <= 1'b0; // R21
      end else if (timer_fault_reg && !battery_above_recharge && !fault_current_on) begin
        timer_fault_reg <= 1'b0; // R19
        detect_reg <= 1'b1; // R19
      end
    end
  end

  // Fault current runs while a below-threshold fault waits for the battery to rise
  logic fault_i_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fault_i_reg <= 1'b0;
    end else if (timer_expired && charging && !battery_above_recharge) begin
      fault_i_reg <= 1'b1; // R20
    end else if (battery_above_recharge || !timer_fault_reg) begin
      fault_i_reg <= 1'b0; // R20
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      blink_cnt_reg <= 32'h0;
      blink_reg <= 1'b0;
    end else if (cnt_done(blink_cnt_reg, BLINK_CYC)) begin
      blink_cnt_reg <= 32'h0;
      blink_reg <= !blink_reg; // R25
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  wire run_now = (state_reg == CFS_RUN);
  wire blink_cond = latch_reg || (charge_request && !in_window) || input_ov ||
                    battery_ov_cmp || timer_fault_reg || battery_absent; // R16 R24
  wire on_cond = charging && !charge_complete; // R22

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_out <= 1'b0;
    end else if (blink_cond) begin
      status_out <= blink_reg; // R24
    end else begin
      status_out <= on_cond; // R22 R23
    end
  end

  assign status_drive_en = status_out;
  assign converter_enable = run_now && !overheat_reg; // R18
  assign high_side_allow = converter_enable && !battery_ov_cmp; // R5
  assign low_side_allow = converter_enable && !battery_short_cmp; // R4
  assign discharge_sink_on = battery_ov_cmp; // R6
  assign precharge_select = short_seen_reg; // R2
  assign half_current = cold_zone; // R10 R12
  assign current_reduce = junction_regulation_hit; // R17
  assign soft_start_step = step_reg;
  assign fb_target_sel = cold_zone ? `CFS_FB_COLD :
                         (warm_zone ? `CFS_FB_WARM : `CFS_FB_NORMAL); // R10 R11 R12 R13
  assign adapter_path_switch = adapter_present; // R14
  assign fault_current_on = fault_i_reg; // R20
  assign detect_start = detect_reg; // R19

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  short_off_a: assert property (state_reg == CFS_RUN && short_now && ok_to_run && // R2
    !switch_short_cmp |=> !converter_enable) else $error("short did not stop");
  hs_block_a: assert property (battery_ov_cmp |-> !high_side_allow) // R5
    else $error("high side on in ov");
  ls_block_a: assert property (battery_short_cmp |-> !low_side_allow) // R4
    else $error("low side on in short");
  window_off_a: assert property (!in_window |=> !converter_enable) // R9
    else $error("ran outside window");
  latch_hold_a: assert property (latch_reg && !adapter_rise |=> latch_reg) // R15
    else $error("latch released");
  latch_off_a: assert property (latch_reg |-> !converter_enable && adapter_path_switch // R14
    || !adapter_present) else $error("latched yet running");
  heat_off_a: assert property (overheat_reg |-> !converter_enable) // R18
    else $error("ran while hot");
  cold_zone_a: assert property (cold_zone |-> half_current && fb_target_sel == `CFS_FB_COLD) // R10
    else $error("cold zone wrong");
  sink_a: assert property (battery_ov_cmp |-> discharge_sink_on) // R6
    else $error("sink off in ov");
  latch_blink_a: assert property (latch_reg |=> status_out == $past(blink_reg)) // R16
    else $error("latch not blinking");
  status_on_a: assert property (on_cond && !blink_cond |=> status_out) // R22
    else $error("status off while charging");
  ov_stop_a: assert property (ov_disable_reg |=> !converter_enable) // R7
    else $error("ran after ov disable");

  cover_run_c: cover property (state_reg == CFS_IDLE ##1 state_reg == CFS_RUN);
  cover_short_c: cover property (state_reg == CFS_SHORT ##1 state_reg == CFS_RUN);
  cover_latch_c: cover property (state_reg == CFS_LATCH);
  cover_detect_c: cover property (detect_start);
endmodule
`default_nettype wire

// ### test/cfs_pack_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Battery pack thermistor and status line
// ****************************************
module cfs_pack_model (
  input wire logic [2:0] zone,
  input wire logic status_drive_en,
  output logic above_cold,
  output logic above_cool,
  output logic above_norm,
  output logic above_warm,
  output logic above_hot,
  output logic status_pin
);
  // Zone 0 is below the coldest limit, zone 5 above the hottest
  assign above_cold = zone > 3'h0;
  assign above_cool = zone > 3'h1;
  assign above_norm = zone > 3'h2;
  assign above_warm = zone > 3'h3;
  assign above_hot = zone > 3'h4;
  // Pull-up holds the line high when the transistor is released
  assign status_pin = status_drive_en ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfs_cfg.svh"
module tb_top;
  localparam int SOFF = 4;
  localparam int STEP = 8;
  localparam int OV = 20;
  localparam int BLINK = 4;
  logic clk = 1'b0, nrst = 1'b0, charge_request = 1'b0, adapter_present = 1'b0;
  logic current_program_disable = 1'b0, battery_short_cmp = 1'b0, battery_ov_cmp = 1'b0;
  logic junction_regulation_hit = 1'b0, junction_overheat_limit = 1'b0;
  logic junction_release_below = 1'b0, switch_short_cmp = 1'b0, timer_expired = 1'b0;
  logic battery_above_recharge = 1'b1, charge_complete = 1'b0, input_ov = 1'b0;
  logic battery_absent = 1'b0, win;
  logic [2:0] zone = 3'h2;
  logic above_cold_window_limit, above_cool_zone_limit, above_normal_zone_upper_limit;
  logic above_warm_zone_limit, above_hot_window_limit, status_pin;
  logic converter_enable, high_side_allow, low_side_allow, discharge_sink_on;
  logic precharge_select, half_current, current_reduce, adapter_path_switch;
  logic fault_current_on, detect_start, status_drive_en, status_out;
  logic [3:0] soft_start_step;
  logic [1:0] fb_target_sel;
  logic [31:0] seed = 32'hee3a;
  int fails = 0, check_count = 0, n;
  always #10 clk = ~clk;
  cfs_supervisor #(.SHORT_OFF_CYC(SOFF), .STEP_CYC(STEP), .OV_CYC(OV), .BLINK_CYC(BLINK)) dut (
    .clk, .nrst, .charge_request, .adapter_present, .current_program_disable,
    .battery_short_cmp, .battery_ov_cmp, .above_cold_window_limit, .above_cool_zone_limit,
    .above_normal_zone_upper_limit, .above_warm_zone_limit, .above_hot_window_limit,
    .junction_regulation_hit, .junction_overheat_limit, .junction_release_below,
    .switch_short_cmp, .timer_expired, .battery_above_recharge, .charge_complete, .input_ov,
    .battery_absent, .converter_enable, .high_side_allow, .low_side_allow,
    .discharge_sink_on, .precharge_select, .half_current, .current_reduce, .soft_start_step,
    .fb_target_sel, .adapter_path_switch, .fault_current_on, .detect_start,
    .status_drive_en, .status_out);
  cfs_pack_model pack (.zone(zone), .status_drive_en(status_drive_en),
    .above_cold(above_cold_window_limit), .above_cool(above_cool_zone_limit),
    .above_norm(above_normal_zone_upper_limit), .above_warm(above_warm_zone_limit),
    .above_hot(above_hot_window_limit), .status_pin(status_pin));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [1:0] exp_fb(input logic [2:0] z);
    return z == 3'h1 ? `CFS_FB_COLD : (z == 3'h4 ? `CFS_FB_WARM : `CFS_FB_NORMAL);
  endfunction
  task automatic finish_test();
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_en(input logic v);
    n = 0;
    while (converter_enable !== v && n < 40) begin
      cyc(1);
      n++;
    end
  endtask
  // Counts status line toggles over four blink periods
  task automatic blink(input logic [3:0] exp);
    logic p;
    cyc(3);
    p = status_pin;
    n = 0;
    repeat (8 * BLINK) begin
      cyc(1);
      if (status_pin !== p) n++;
      p = status_pin;
    end
    chk(n[3:0], exp);
  endtask
  // Clears every fault and waits for the converter to run again
  task automatic clean();
    {battery_short_cmp, battery_ov_cmp, switch_short_cmp, timer_expired} = 4'h0;
    {charge_complete, input_ov, battery_absent, junction_overheat_limit} = 4'h0;
    zone = 3'h2;
    battery_above_recharge = 1'b1;
    {adapter_present, current_program_disable, junction_release_below} = 3'h3;
    cyc(2);
    {adapter_present, current_program_disable, junction_release_below} = 3'h4;
    wait_en(1'b1);
  endtask
  initial begin
    #200000;
    fails++;
    finish_test();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    cyc(8);
    nrst = 1'b1;
    cyc(1);
    chk(converter_enable, 1'b0);
    chk(status_drive_en, 1'b0);
    chk(status_out, 1'b0);
    charge_request = 1'b1;
    clean();
    chk(converter_enable, 1'b1);
    cyc(3 * STEP + 4);
    chk(soft_start_step, 4'h3);
    cyc(5 * STEP + 4);
    chk(soft_start_step, 4'h8);
    chk(status_pin, 1'b0);
    blink(4'h0);
    for (int i = 0; i < 14; i++) begin
      void'(rnd());
      zone = i < 6 ? 3'(i) : 3'(seed % 6);
      junction_regulation_hit = seed[9];
      cyc(3);
      win = zone inside {[1:4]};
      chk(converter_enable, win);
      chk(current_reduce, junction_regulation_hit);
      if (win) chk(fb_target_sel, exp_fb(zone));
      if (win) chk(half_current, zone == 3'h1);
      if (!win) chk({high_side_allow, low_side_allow}, 2'h0);
    end
    zone = 3'h5;
    blink(4'h8);
    clean();
    battery_short_cmp = 1'b1;
    cyc(1);
    chk(converter_enable, 1'b0);
    chk(low_side_allow, 1'b0);
    battery_short_cmp = 1'b0;
    cyc(SOFF - 2);
    chk(converter_enable, 1'b0);
    wait_en(1'b1);
    chk(precharge_select, 1'b1);
    clean();
    chk(precharge_select, 1'b0);
    battery_ov_cmp = 1'b1;
    #1;
    chk({discharge_sink_on, high_side_allow}, 2'h2);
    cyc(OV / 2);
    chk(converter_enable, 1'b1);
    cyc(OV / 2 + 4);
    battery_ov_cmp = 1'b0;
    cyc(2);
    chk(converter_enable, 1'b0);
    clean();
    switch_short_cmp = 1'b1;
    cyc(1);
    switch_short_cmp = 1'b0;
    cyc(1);
    chk({converter_enable, adapter_path_switch}, 2'h1);
    blink(4'h8);
    current_program_disable = 1'b1;
    cyc(2);
    current_program_disable = 1'b0;
    cyc(2);
    chk(converter_enable, 1'b0);
    clean();
    chk(converter_enable, 1'b1);
    junction_overheat_limit = 1'b1;
    cyc(1);
    junction_overheat_limit = 1'b0;
    cyc(3);
    chk(converter_enable, 1'b0);
    junction_release_below = 1'b1;
    cyc(1);
    junction_release_below = 1'b0;
    wait_en(1'b1);
    chk(converter_enable, 1'b1);
    timer_expired = 1'b1;
    cyc(1);
    timer_expired = 1'b0;
    cyc(2);
    chk(converter_enable, 1'b0);
    blink(4'h8);
    battery_above_recharge = 1'b0;
    n = 0;
    while (detect_start !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    chk(detect_start, 1'b1);
    clean();
    battery_above_recharge = 1'b0;
    cyc(2);
    timer_expired = 1'b1;
    cyc(1);
    timer_expired = 1'b0;
    cyc(2);
    chk(fault_current_on, 1'b1);
    battery_above_recharge = 1'b1;
    cyc(2);
    chk(fault_current_on, 1'b0);
    clean();
    chk(converter_enable, 1'b1);
    for (int i = 1; i < 3; i++) begin
      clean();
      {input_ov, battery_absent} = 2'(i);
      blink(4'h8);
    end
    clean();
    charge_complete = 1'b1;
    cyc(3);
    chk(status_pin, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
